// file: src/sad_decoder.v
// system address decoder: region decode, bus routing, bit alias, splitting
`timescale 1ns/1ns
`default_nettype none
`include "sad_map.vh"
module sad_decoder (
  // clock and reset
  input  wire        i_mclk,
  input  wire        i_arst_n,
  // access request from the processor masters
  input  wire        i_req,
  input  wire [1:0]  i_master,
  input  wire        i_instr,
  input  wire        i_write,
  input  wire [1:0]  i_size,
  input  wire [31:0] i_addr,
  input  wire [31:0] i_wdata,
  output reg         o_ack,
  output reg         o_err,
  output reg  [31:0] o_rdata,
  // on-chip target bus
  output reg         o_tgt_req,
  output reg  [2:0]  o_tgt_sel,
  output reg  [1:0]  o_tgt_route,
  output reg         o_tgt_write,
  output reg         o_tgt_lock,
  output reg  [31:0] o_tgt_addr,
  output reg  [3:0]  o_tgt_be,
  output reg  [31:0] o_tgt_wdata,
  input  wire        i_tgt_ack,
  input  wire [31:0] i_tgt_rdata,
  // external memory configuration
  input  wire        i_em_sync,
  input  wire        i_em_wide,
  // external memory pins
  output wire [23:0] o_em_addr,
  output wire [15:0] o_em_wdata,
  output wire        o_em_doe,
  input  wire [15:0] i_em_rdata,
  output wire        o_em_cs_n,
  output wire        o_em_rd_n,
  output wire        o_em_we_n,
  output wire        o_em_clk
);
  localparam ST_IDLE  = 3'd0;
  localparam ST_ISSUE = 3'd1;
  localparam ST_WAIT  = 3'd2;
  localparam ST_BBWR  = 3'd3;
  localparam ST_BBWT  = 3'd4;

  // region of a full address
  function [2:0] region_of;
    input [31:0] a;
    begin
      case (a[31:29])
        `SAD_TOP_CODE:
          region_of = `SAD_RG_CODE;
        `SAD_TOP_SRAM:
          region_of = `SAD_RG_SRAM;
        `SAD_TOP_PERI:
          region_of = (a[31:8] == `SAD_EMCTL_PAGE) ?
                      `SAD_RG_EMCTL : `SAD_RG_PERI;
        `SAD_TOP_XRAM_LO, `SAD_TOP_XRAM_HI:
          region_of = `SAD_RG_XRAM;
        `SAD_TOP_XPER_LO, `SAD_TOP_XPER_HI:
          region_of = `SAD_RG_XPER;
        default:
          region_of = (a[31:20] == `SAD_PPB_TOP) ?
                      `SAD_RG_PPB : `SAD_RG_INT;
      endcase
    end
  endfunction

  // byte lanes touched by an access of a given size
  function [3:0] size_mask;
    input [1:0] s;
    begin
      case (s)
        `SAD_SZ_BYTE: size_mask = 4'h1;
        `SAD_SZ_HALF: size_mask = 4'h3;
        default:      size_mask = 4'hF;
      endcase
    end
  endfunction

  // expand byte lanes into a bit mask
  function [31:0] lane_bits;
    input [3:0] m;
    begin
      lane_bits = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
    end
  endfunction

  // decode of the incoming request
  wire [2:0]  rg      = region_of(i_addr);
  wire        is_alias = (i_addr[31:25] == `SAD_ALIAS_TOP);
  wire        code_m  = (i_master != `SAD_M_SYS);
  wire        in_win  = (i_addr[31:24] == `SAD_EM_BASE);
  wire [3:0]  smask   = size_mask(i_size);
  wire [7:0]  m8      = {4'h0, smask} << i_addr[1:0];
  wire [63:0] wd64    = {32'h0, i_wdata} << {i_addr[1:0], 3'h0};
  // bit alias: word offset is addr[24:7], bit is addr[6:2]
  wire [31:0] bb_word = `SAD_SRAM_BASE +
                        {12'h0, i_addr[24:7], 2'h0};

  reg         bad;
  reg  [1:0]  route;

  // route choice and refusal; no protection is applied anywhere
  always @* begin
    bad = 1'b0;
    route = `SAD_RT_SYS;
    if (rg == `SAD_RG_CODE) begin
      route = (i_master == `SAD_M_ICODE) ?
              `SAD_RT_ICODE : `SAD_RT_DCODE;
      if (!code_m)
        bad = 1'b1;
    end else begin
      if (code_m)
        bad = 1'b1;
      if (rg == `SAD_RG_PPB)
        route = `SAD_RT_PPB;
      if (rg == `SAD_RG_XRAM && !in_win)
        bad = 1'b1;
      if (i_instr) begin
        if (rg == `SAD_RG_XRAM)
          bad = bad | ~i_em_wide;
        else if (rg != `SAD_RG_SRAM)
          bad = 1'b1;
      end
    end
  end

  // latched request state
  reg  [2:0]  st_q;
  reg  [31:0] a_q;
  reg  [7:0]  m8_q;
  reg  [63:0] wd64_q;
  reg  [63:0] rd_q;
  reg  [1:0]  off_q;
  reg  [3:0]  smask_q;
  reg         wr_q;
  reg         split_q;
  reg         beat_q;
  reg         ext_q;
  reg         bb_q;
  reg  [4:0]  bit_q;
  reg         wbit_q;
  reg         em_start_q;

  // answer from whichever target served the beat
  wire        em_done;
  wire [31:0] em_rdata;
  wire        beat_ack  = ext_q ? em_done : i_tgt_ack;
  wire [31:0] beat_data = ext_q ? em_rdata : i_tgt_rdata;
  wire [63:0] cur64     = beat_q ? {beat_data, rd_q[31:0]}
                                 : {32'h0, beat_data};
  wire [63:0] shifted   = cur64 >> {off_q, 3'h0};
  wire [31:0] merged    = shifted[31:0] & lane_bits(smask_q);
  wire [31:0] bb_mod    = (rd_q[31:0] & ~(32'h1 << bit_q)) |
                          ({31'h0, wbit_q} << bit_q);

  // access sequencer: one or two beats, or a locked read-modify-write
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= ST_IDLE;
      a_q <= 32'h0;
      m8_q <= 8'h0;
      wd64_q <= 64'h0;
      rd_q <= 64'h0;
      off_q <= 2'h0;
      smask_q <= 4'h0;
      wr_q <= 1'b0;
      split_q <= 1'b0;
      beat_q <= 1'b0;
      ext_q <= 1'b0;
      bb_q <= 1'b0;
      bit_q <= 5'h0;
      wbit_q <= 1'b0;
      em_start_q <= 1'b0;
      o_ack <= 1'b0;
      o_err <= 1'b0;
      o_rdata <= 32'h0;
      o_tgt_req <= 1'b0;
      o_tgt_sel <= 3'h0;
      o_tgt_route <= 2'h0;
      o_tgt_write <= 1'b0;
      o_tgt_lock <= 1'b0;
      o_tgt_addr <= 32'h0;
      o_tgt_be <= 4'h0;
      o_tgt_wdata <= 32'h0;
    end else begin
      o_ack <= 1'b0;
      em_start_q <= 1'b0;
      case (st_q)
        ST_IDLE: if (i_req && !o_ack) begin
          if (bad) begin
            o_ack <= 1'b1;
            o_err <= 1'b1;
            o_rdata <= 32'h0;
          end else begin
            o_err <= 1'b0;
            o_tgt_sel <= rg;
            o_tgt_route <= route;
            ext_q <= (rg == `SAD_RG_XRAM);
            wr_q <= i_write;
            beat_q <= 1'b0;
            rd_q <= 64'h0;
            bb_q <= is_alias;
            bit_q <= i_addr[6:2];
            wbit_q <= i_wdata[0];
            if (is_alias) begin
              a_q <= bb_word;
              m8_q <= 8'h0F;
              off_q <= 2'h0;
              smask_q <= 4'hF;
              split_q <= 1'b0;
              wd64_q <= 64'h0;
            end else begin
              a_q <= {i_addr[31:2], 2'h0};
              m8_q <= m8;
              off_q <= i_addr[1:0];
              smask_q <= smask;
              split_q <= |m8[7:4];
              wd64_q <= wd64;
            end
            st_q <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          o_tgt_addr <= beat_q ? a_q + 32'h4 : a_q;
          o_tgt_be <= beat_q ? m8_q[7:4] : m8_q[3:0];
          o_tgt_wdata <= beat_q ? wd64_q[63:32] : wd64_q[31:0];
          o_tgt_write <= wr_q & ~bb_q;
          o_tgt_lock <= bb_q & wr_q;
          if (ext_q)
            em_start_q <= 1'b1;
          else
            o_tgt_req <= 1'b1;
          st_q <= ST_WAIT;
        end
        ST_WAIT: if (beat_ack) begin
          o_tgt_req <= 1'b0;
          rd_q <= cur64;
          if (bb_q && wr_q) begin
            st_q <= ST_BBWR;
          end else if (bb_q) begin
            o_rdata <= {31'h0, beat_data[bit_q]};
            o_ack <= 1'b1;
            st_q <= ST_IDLE;
          end else if (split_q && !beat_q) begin
            beat_q <= 1'b1;
            st_q <= ST_ISSUE;
          end else begin
            o_rdata <= wr_q ? 32'h0 : merged;
            o_ack <= 1'b1;
            st_q <= ST_IDLE;
          end
        end
        ST_BBWR: begin
          o_tgt_write <= 1'b1;
          o_tgt_be <= 4'hF;
          o_tgt_wdata <= bb_mod;
          o_tgt_req <= 1'b1;
          st_q <= ST_BBWT;
        end
        ST_BBWT: if (i_tgt_ack) begin
          o_tgt_req <= 1'b0;
          o_tgt_lock <= 1'b0;
          o_rdata <= 32'h0;
          o_ack <= 1'b1;
          st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // external memory port; its pins leave through shared fabric
  sad_ext_port u_ext (
    .i_mclk     (i_mclk),
    .i_arst_n   (i_arst_n),
    .i_start    (em_start_q),
    .i_write    (o_tgt_write),
    .i_addr     (o_tgt_addr[23:0]),
    .i_be       (o_tgt_be),
    .i_wdata    (o_tgt_wdata),
    .i_wide     (i_em_wide),
    .i_sync     (i_em_sync),
    .o_done     (em_done),
    .o_rdata    (em_rdata),
    .o_em_addr  (o_em_addr),
    .o_em_wdata (o_em_wdata),
    .o_em_doe   (o_em_doe),
    .i_em_rdata (i_em_rdata),
    .o_em_cs_n  (o_em_cs_n),
    .o_em_rd_n  (o_em_rd_n),
    .o_em_we_n  (o_em_we_n),
    .o_em_clk   (o_em_clk)
  );
endmodule
`default_nettype wire

// file: src/sad_map.vh
// address map, route codes and timing counts for the system address decoder
`ifndef SAD_MAP_VH
`define SAD_MAP_VH
// address bits 31:29 of each half-gigabyte region
`define SAD_TOP_CODE    3'h0
`define SAD_TOP_SRAM    3'h1
`define SAD_TOP_PERI    3'h2
`define SAD_TOP_XRAM_LO 3'h3
`define SAD_TOP_XRAM_HI 3'h4
`define SAD_TOP_XPER_LO 3'h5
`define SAD_TOP_XPER_HI 3'h6
// finer decode fields
`define SAD_ALIAS_TOP   7'h11
`define SAD_SRAM_BASE   32'h20000000
`define SAD_EMCTL_PAGE  24'h400054
`define SAD_EM_BASE     8'h60
`define SAD_PPB_TOP     12'hE00
// target region codes
`define SAD_RG_CODE     3'h0
`define SAD_RG_SRAM     3'h1
`define SAD_RG_PERI     3'h2
`define SAD_RG_EMCTL    3'h3
`define SAD_RG_XRAM     3'h4
`define SAD_RG_XPER     3'h5
`define SAD_RG_PPB      3'h6
`define SAD_RG_INT      3'h7
// route codes
`define SAD_RT_ICODE    2'h0
`define SAD_RT_DCODE    2'h1
`define SAD_RT_SYS      2'h2
`define SAD_RT_PPB      2'h3
// master codes
`define SAD_M_ICODE     2'h0
`define SAD_M_DCODE     2'h1
`define SAD_M_SYS       2'h2
// access size codes
`define SAD_SZ_BYTE     2'h0
`define SAD_SZ_HALF     2'h1
// bus cycles per external memory access
`define SAD_EM_ACC_CYC  3'h4
`endif

// file: src/sad_ext_port.v
// external memory port: one access of four bus cycles per 8/16-bit unit
`timescale 1ns/1ns
`default_nettype none
`include "sad_map.vh"
module sad_ext_port (
  // clock and reset
  input  wire        i_mclk,
  input  wire        i_arst_n,
  // beat request from the decoder
  input  wire        i_start,
  input  wire        i_write,
  input  wire [23:0] i_addr,
  input  wire [3:0]  i_be,
  input  wire [31:0] i_wdata,
  input  wire        i_wide,
  input  wire        i_sync,
  output reg         o_done,
  output reg  [31:0] o_rdata,
  // memory pins, routed through digital blocks and ports
  output reg  [23:0] o_em_addr,
  output reg  [15:0] o_em_wdata,
  output reg         o_em_doe,
  input  wire [15:0] i_em_rdata,
  output reg         o_em_cs_n,
  output reg         o_em_rd_n,
  output reg         o_em_we_n,
  output reg         o_em_clk
);
  localparam ST_IDLE = 2'd0;
  localparam ST_SCAN = 2'd1;
  localparam ST_RUN  = 2'd2;

  reg  [1:0]  st_q;
  reg  [2:0]  ph_q;
  reg  [1:0]  u_q;
  reg         wr_q;
  reg         wide_q;
  reg         sync_q;
  reg  [23:0] a_q;
  reg  [3:0]  be_q;
  reg  [31:0] wd_q;

  // unit enable and last unit for the latched width
  wire u_en   = wide_q ? |(be_q >> {u_q[0], 1'b0}) & 1'b1
                         & (be_q[{u_q[0], 1'b1}] | be_q[{u_q[0], 1'b0}])
                       : be_q[u_q];
  wire u_last = wide_q ? u_q[0] : (u_q == 2'h3);
  wire ph_end = (ph_q == `SAD_EM_ACC_CYC - 3'h1);

  // unit sequencer; type and width are frozen for the whole beat
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= ST_IDLE;
      ph_q <= 3'h0;
      u_q <= 2'h0;
      wr_q <= 1'b0;
      wide_q <= 1'b0;
      sync_q <= 1'b0;
      a_q <= 24'h0;
      be_q <= 4'h0;
      wd_q <= 32'h0;
      o_done <= 1'b0;
      o_rdata <= 32'h0;
      o_em_addr <= 24'h0;
      o_em_wdata <= 16'h0;
      o_em_doe <= 1'b0;
      o_em_cs_n <= 1'b1;
      o_em_rd_n <= 1'b1;
      o_em_we_n <= 1'b1;
      o_em_clk <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (st_q)
        ST_IDLE: if (i_start) begin
          wr_q <= i_write;
          wide_q <= i_wide;
          sync_q <= i_sync;
          a_q <= i_addr;
          be_q <= i_be;
          wd_q <= i_wdata;
          u_q <= 2'h0;
          o_rdata <= 32'h0;
          st_q <= ST_SCAN;
        end
        ST_SCAN: if (u_en) begin
          ph_q <= 3'h0;
          o_em_cs_n <= 1'b0;
          o_em_doe <= wr_q;
          o_em_addr <= wide_q ? {a_q[23:2], u_q[0], 1'b0}
                              : {a_q[23:2], u_q};
          o_em_wdata <= wide_q ? wd_q[{u_q[0], 4'h0} +: 16]
                               : {8'h0, wd_q[{u_q, 3'h0} +: 8]};
          st_q <= ST_RUN;
        end else if (u_last) begin
          o_done <= 1'b1;
          st_q <= ST_IDLE;
        end else begin
          u_q <= u_q + 2'h1;
        end
        ST_RUN: begin
          ph_q <= ph_q + 3'h1;
          o_em_clk <= sync_q & ~ph_q[0];
          o_em_rd_n <= ~(~wr_q & ~ph_end);
          o_em_we_n <= ~(wr_q & (ph_q == 3'h0)); // strobe only in cycle 2
          if (ph_end) begin
            o_em_cs_n <= 1'b1;
            o_em_doe <= 1'b0;
            o_em_clk <= 1'b0;
            if (!wr_q && wide_q)
              o_rdata[{u_q[0], 4'h0} +: 16] <= i_em_rdata;
            else if (!wr_q)
              o_rdata[{u_q, 3'h0} +: 8] <= i_em_rdata[7:0];
            if (u_last) begin
              o_done <= 1'b1;
              st_q <= ST_IDLE;
            end else begin
              u_q <= u_q + 2'h1;
              st_q <= ST_SCAN;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: src/README_unused.v
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// file: bench/sad_decoder_checker.sv
// port assertions for the system address decoder
`timescale 1ns/1ns
`default_nettype none
`include "sad_map.vh"
module sad_decoder_checker (
  // clock, reset and request
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  input  wire logic        i_write,
  input  wire logic        i_em_sync,
  // target bus
  input  wire logic        o_tgt_req,
  input  wire logic [2:0]  o_tgt_sel,
  input  wire logic [1:0]  o_tgt_route,
  input  wire logic [31:0] o_tgt_addr,
  input  wire logic        i_tgt_ack,
  // memory pins
  input  wire logic [23:0] o_em_addr,
  input  wire logic        o_em_doe,
  input  wire logic        o_em_cs_n,
  input  wire logic        o_em_rd_n,
  input  wire logic        o_em_we_n,
  input  wire logic        o_em_clk
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  // pin timing of one memory unit
  AST_EM_FOUR: assert property ($fell(o_em_cs_n) |->
    (!o_em_cs_n) [*4] ##1 o_em_cs_n) else $error("select not 4 cycles");
  AST_EM_READ: assert property ($fell(o_em_cs_n) && !i_write |->
    o_em_rd_n ##1 (!o_em_rd_n) [*3]) else $error("read strobe wrong");
  AST_EM_WRITE: assert property ($fell(o_em_cs_n) && i_write |->
    o_em_we_n ##1 (!o_em_we_n && o_em_doe) ##1 o_em_we_n)
    else $error("write strobe wrong");
  AST_EM_ADDR: assert property (!o_em_cs_n && !$past(o_em_cs_n) |->
    $stable(o_em_addr)) else $error("memory address moved");
  AST_EM_SCLK: assert property ($fell(o_em_cs_n) && i_em_sync |->
    !o_em_clk ##1 o_em_clk ##1 !o_em_clk ##1 o_em_clk)
    else $error("memory clock wrong");
  AST_EM_ACLK: assert property (!i_em_sync |-> !o_em_clk)
    else $error("memory clock in async mode");
  // target bus handshake and routing
  AST_TGT_HOLD: assert property (o_tgt_req && !i_tgt_ack |=>
    o_tgt_req && $stable(o_tgt_addr)) else $error("beat not held");
  AST_TGT_DROP: assert property (o_tgt_req && i_tgt_ack |=> !o_tgt_req)
    else $error("beat not dropped");
  AST_CODE_BUS: assert property (o_tgt_req && o_tgt_route < `SAD_RT_SYS |->
    o_tgt_addr[31:29] == 3'h0) else $error("code bus out of range");
  AST_SYS_BUS: assert property (o_tgt_req && o_tgt_addr[31:29] != 3'h0 &&
    o_tgt_sel != `SAD_RG_PPB |-> o_tgt_route == `SAD_RT_SYS)
    else $error("system bus not used");
  AST_PPB: assert property (o_tgt_req && o_tgt_addr[31:20] == 12'hE00 |->
    o_tgt_sel == `SAD_RG_PPB && o_tgt_route == `SAD_RT_PPB)
    else $error("private bus not used");
  AST_EMCTL: assert property (o_tgt_req && o_tgt_addr[31:8] == 24'h400054
    |-> o_tgt_sel == `SAD_RG_EMCTL) else $error("port registers missed");
endmodule
bind sad_decoder sad_decoder_checker sad_decoder_checker_inst (
  .i_mclk, .i_arst_n, .i_write, .i_em_sync, .o_tgt_req, .o_tgt_sel,
  .o_tgt_route, .o_tgt_addr, .i_tgt_ack, .o_em_addr, .o_em_doe,
  .o_em_cs_n, .o_em_rd_n, .o_em_we_n, .o_em_clk
);
`default_nettype wire

// file: bench/sad_tgt_model.sv
// target and external memory model facing the decoder
`timescale 1ns/1ns
`default_nettype none
module sad_tgt_model (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  // target bus
  input  wire logic        i_req,
  input  wire logic        i_write,
  input  wire logic [31:0] i_addr,
  input  wire logic [3:0]  i_be,
  input  wire logic [31:0] i_wdata,
  output logic             o_ack,
  output logic [31:0]      o_rdata,
  // memory pins
  input  wire logic [23:0] i_em_addr,
  input  wire logic        i_em_rd_n,
  output logic [15:0]      o_em_rdata
);
  logic [31:0] mem [64];
  logic [1:0]  wait_q;
  logic        slow_q;
  logic [15:0] em_last;
  // each byte starts out holding its own low address byte
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = {8'(4*i+3), 8'(4*i+2), 8'(4*i+1), 8'(4*i)};
    end
  end
  // answer beats alternately at once and after two idle cycles
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ack <= 1'b0;
      o_rdata <= 32'h0;
      wait_q <= 2'h0;
      slow_q <= 1'b0;
    end else if (o_ack) begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata; // data is gone after the answer
    end else if (i_req && wait_q == {slow_q, 1'b0}) begin
      o_ack <= 1'b1;
      wait_q <= 2'h0;
      slow_q <= ~slow_q;
      o_rdata <= mem[i_addr[7:2]];
      for (int i = 0; i < 4; i++) begin
        if (i_write && i_be[i]) begin
          mem[i_addr[7:2]][8*i+:8] <= i_wdata[8*i+:8];
        end
      end
    end else if (i_req) begin
      wait_q <= wait_q + 2'h1;
    end
  end
  // memory data is valid only while read strobe is low; otherwise the last value inverted
  assign o_em_rdata = i_em_rd_n ? ~em_last
                                : {i_em_addr[7:0] + 8'h01, i_em_addr[7:0]};
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      em_last <= 16'h0;
    end else if (!i_em_rd_n) begin
      em_last <= o_em_rdata;
    end
  end
endmodule
`default_nettype wire

// file: bench/test_sad_decoder.sv
// self-checking bench for the system address decoder
`timescale 1ns/1ns
`default_nettype none
`include "sad_map.vh"
module test_sad_decoder;
  logic        i_mclk = 1'b0;
  logic        i_arst_n = 1'b0;
  logic        i_req = 1'b0;
  logic [1:0]  i_master = 2'h0;
  logic        i_instr = 1'b0;
  logic        i_write = 1'b0;
  logic [1:0]  i_size = 2'h0;
  logic [31:0] i_addr = 32'h0;
  logic [31:0] i_wdata = 32'h0;
  logic        i_em_sync = 1'b0;
  logic        i_em_wide = 1'b1;
  wire logic        o_ack, o_err, o_tgt_req, o_tgt_write, i_tgt_ack;
  wire logic        o_em_doe, o_em_cs_n, o_em_rd_n, o_em_we_n, o_em_clk;
  wire logic [2:0]  o_tgt_sel;
  wire logic [1:0]  o_tgt_route;
  wire logic [3:0]  o_tgt_be;
  wire logic [31:0] o_rdata, o_tgt_addr, o_tgt_wdata, i_tgt_rdata;
  wire logic [23:0] o_em_addr;
  wire logic [15:0] i_em_rdata;
  logic [31:0] rd;
  logic        er;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  sad_decoder sad_decoder_inst (
    .i_mclk, .i_arst_n, .i_req, .i_master, .i_instr, .i_write, .i_size,
    .i_addr, .i_wdata, .o_ack, .o_err, .o_rdata, .o_tgt_req, .o_tgt_sel,
    .o_tgt_route, .o_tgt_write, .o_tgt_lock(), .o_tgt_addr, .o_tgt_be,
    .o_tgt_wdata, .i_tgt_ack, .i_tgt_rdata, .i_em_sync, .i_em_wide,
    .o_em_addr, .o_em_wdata(), .o_em_doe, .i_em_rdata, .o_em_cs_n,
    .o_em_rd_n, .o_em_we_n, .o_em_clk
  );
  sad_tgt_model sad_tgt_model_inst (
    .i_mclk, .i_arst_n, .i_req(o_tgt_req), .i_write(o_tgt_write),
    .i_addr(o_tgt_addr), .i_be(o_tgt_be), .i_wdata(o_tgt_wdata),
    .o_ack(i_tgt_ack), .o_rdata(i_tgt_rdata), .i_em_addr(o_em_addr),
    .i_em_rd_n(o_em_rd_n), .o_em_rdata(i_em_rdata)
  );
  // clock and hang limit
  always #25 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 8000) begin
      bad_count++;
      results();
    end
  end
  task automatic results;
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one request held until its answer, then released
  task automatic acc(input logic [1:0] m, input logic ins, input logic w,
                     input logic [1:0] sz, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge i_mclk);
    i_req <= 1'b1;
    i_master <= m;
    i_instr <= ins;
    i_write <= w;
    i_size <= sz;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    while (o_ack !== 1'b1) begin
      @(posedge i_mclk);
    end
    rd = o_rdata;
    er = o_err;
    i_req <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic t_code;
    acc(`SAD_M_ICODE, 1'b1, 1'b0, 2'h2, 32'h00000008, 32'h0);
    chk("fetch", 32'h0B0A0908, rd);
    chk("fetch route", 32'(`SAD_RT_ICODE), 32'(o_tgt_route));
    acc(`SAD_M_DCODE, 1'b0, 1'b0, 2'h2, 32'h1FFFFFFC, 32'h0);
    chk("code top", 32'hFFFEFDFC, rd);
    chk("data route", 32'(`SAD_RT_DCODE), 32'(o_tgt_route));
    acc(`SAD_M_ICODE, 1'b0, 1'b0, 2'h2, 32'h20000000, 32'h0);
    chk("code bus refused", 32'h1, 32'(er));
    acc(`SAD_M_SYS, 1'b0, 1'b0, 2'h2, 32'h00000004, 32'h0);
    chk("system bus refused", 32'h1, 32'(er));
    chk("refused data", 32'h0, rd);
  endtask
  task automatic t_sram;
    acc(`SAD_M_SYS, 1'b0, 1'b1, 2'h2, 32'h20000040, 32'hCAFEF00D);
    chk("sram region", 32'(`SAD_RG_SRAM), 32'(o_tgt_sel));
    acc(`SAD_M_SYS, 1'b0, 1'b0, 2'h2, 32'h20000040, 32'h0);
    chk("sram word", 32'hCAFEF00D, rd);
    acc(`SAD_M_SYS, 1'b0, 1'b0, 2'h2, 32'h20000042, 32'h0);
    chk("unaligned word", 32'h4544CAFE, rd);
    acc(`SAD_M_SYS, 1'b0, 1'b0, 2'h1, 32'h20000043, 32'h0);
    chk("unaligned half", 32'h000044CA, rd);
    acc(`SAD_M_SYS, 1'b1, 1'b0, 2'h2, 32'h20000044, 32'h0);
    chk("sram fetch", 32'h47464544, rd);
  endtask
  task automatic t_map;
    logic [31:0] a [6] = '{32'h40005400, 32'h400054FC, 32'h40005500,
                           32'hE0000000, 32'hE0100000, 32'hA0000000};
    logic [2:0]  s [6] = '{3'h3, 3'h3, 3'h2, 3'h6, 3'h7, 3'h5};
    logic [1:0]  r [6] = '{2'h2, 2'h2, 2'h2, 2'h3, 2'h2, 2'h2};
    for (int i = 0; i < 6; i++) begin
      acc(`SAD_M_SYS, 1'b0, 1'b0, 2'h2, a[i], 32'h0);
      chk("region", 32'(s[i]), 32'(o_tgt_sel));
      chk("route", 32'(r[i]), 32'(o_tgt_route));
    end
  endtask
  task automatic t_ext;
    acc(`SAD_M_SYS, 1'b0, 1'b0, 2'h2, 32'h60000010, 32'h0);
    chk("ext wide", 32'h13121110, rd);
    acc(`SAD_M_SYS, 1'b0, 1'b1, 2'h1, 32'h60000020, 32'h0000BEEF);
    chk("ext write", 32'h0, 32'(er));
    acc(`SAD_M_SYS, 1'b1, 1'b0, 2'h2, 32'h60000010, 32'h0);
    chk("ext fetch", 32'h13121110, rd);
    acc(`SAD_M_SYS, 1'b0, 1'b0, 2'h2, 32'h61000000, 32'h0);
    chk("beyond 24 bits", 32'h1, 32'(er));
    i_em_wide <= 1'b0;
    i_em_sync <= 1'b1;
    acc(`SAD_M_SYS, 1'b0, 1'b0, 2'h2, 32'h60000010, 32'h0);
    chk("ext narrow", 32'h13121110, rd);
    acc(`SAD_M_SYS, 1'b1, 1'b0, 2'h2, 32'h60000010, 32'h0);
    chk("narrow fetch", 32'h1, 32'(er));
    i_em_wide <= 1'b1;
    i_em_sync <= 1'b0;
  endtask
  task automatic t_alias;
    acc(`SAD_M_SYS, 1'b0, 1'b1, 2'h2, 32'h2200000C, 32'h00000001);
    acc(`SAD_M_SYS, 1'b0, 1'b0, 2'h2, 32'h20000000, 32'h0);
    chk("bit set", 32'h03020108, rd);
    acc(`SAD_M_SYS, 1'b0, 1'b0, 2'h2, 32'h2200000C, 32'h0);
    chk("bit read", 32'h1, rd);
    acc(`SAD_M_SYS, 1'b0, 1'b0, 2'h2, 32'h22000020, 32'h0);
    chk("next byte bit", 32'h1, rd);
    acc(`SAD_M_SYS, 1'b0, 1'b1, 2'h2, 32'h2200000C, 32'hFFFFFFFE);
    acc(`SAD_M_SYS, 1'b0, 1'b0, 2'h2, 32'h20000000, 32'h0);
    chk("bit clear", 32'h03020100, rd);
  endtask
  // reset, then each scenario in turn
  initial begin
    repeat (2) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    t_code();
    t_sram();
    t_map();
    t_ext();
    t_alias();
    results();
  end
endmodule
`default_nettype wire
